// ==== verilog/vidbuf_defines.svh ====
/*
 * Constants of the video buffer serial control link: target address pattern,
 * channel subaddresses, configuration byte fields, reset values and link timing.
 * Assumes inclusion by bare name from the package and both link ends.
 */
`ifndef VIDBUF_DEFINES_SVH
`define VIDBUF_DEFINES_SVH

// ****************************************************************
// Addressing
// ****************************************************************
`define TGT_ADDR_FIXED   5'b01011
`define DIR_WRITE        1'b0
`define DIR_READ         1'b1
`define SUBADDR_CH1      8'h01
`define SUBADDR_CH2      8'h02
`define SUBADDR_CH3      8'h03
`define NUM_CHAN         3

// ****************************************************************
// Channel configuration byte
// ****************************************************************
`define CFG_MUX_BIT      5
`define CFG_BIAS_MSB     2
`define CFG_BIAS_LSB     0
`define BIAS_DISABLE     3'b000
`define BIAS_MUTE        3'b001
`define CFG_RESET        8'h00
`define RD_UNMAPPED      8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS    10
`define SCL_HALF_NS      5000
`define SCL_HALF_CYC     ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== verilog/vidbuf_pkg.sv ====
/*
 * Types shared by both ends of the video buffer serial control link.
 * Assumes the constants header is on the include path.
 */
`include "vidbuf_defines.svh"

package vidbuf_pkg;
	typedef logic [7:0] cfg_byte_t;

	// Target end: one-hot transaction states
	typedef enum logic [9:0] {
		T_IDLE     = 10'h001,
		T_ADDR     = 10'h002,
		T_ADDR_ACK = 10'h004,
		T_SUB      = 10'h008,
		T_SUB_ACK  = 10'h010,
		T_WDAT     = 10'h020,
		T_WDAT_ACK = 10'h040,
		T_RDAT     = 10'h080,
		T_RACK     = 10'h100,
		T_DONE     = 10'h200
	} tgt_state_t;

	// Controller end: one-hot sequencer states
	typedef enum logic [3:0] {
		C_IDLE  = 4'h1,
		C_START = 4'h2,
		C_BIT   = 4'h4,
		C_STOP  = 4'h8
	} ctl_state_t;
endpackage

// ==== verilog/i2c_link_if.sv ====
/*
 * Two-wire link between the bus controller and the video buffer target.
 * Assumes pull-ups: a line is low only while some party enables a low drive.
 */
interface i2c_link_if;
	logic sclCtlOut;
	logic sclCtlOe;
	logic sdaCtlOut;
	logic sdaCtlOe;
	logic sdaTgtOut;
	logic sdaTgtOe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up resolution of both lines
	assign scl = !(sclCtlOe && !sclCtlOut);
	assign sda = !((sdaCtlOe && !sdaCtlOut) || (sdaTgtOe && !sdaTgtOut));

	modport ctl (
		input  scl,
		input  sda,
		output sclCtlOut,
		output sclCtlOe,
		output sdaCtlOut,
		output sdaCtlOe
	);

	modport tgt (
		input  scl,
		input  sda,
		output sdaTgtOut,
		output sdaTgtOe
	);
endinterface

// ==== verilog/vidbuf_i2c_target.sv ====
/*
 * Serial target end of the three-channel video buffer: address match, channel
 * subaddress, one-byte write and one-byte read of the channel configuration.
 * Assumes scl and sda are synchronous to clock and much slower than it.
 */
`include "vidbuf_defines.svh"

module vidbuf_i2c_target (
	input  wire logic                 clock,
	input  wire logic                 nrst,
	i2c_link_if.tgt                   link,
	input  wire logic                 addr_select_hi_pin,
	input  wire logic                 addr_select_lo_pin,
	output vidbuf_pkg::cfg_byte_t     chanCfg [`NUM_CHAN],
	output logic [`NUM_CHAN-1:0]      inputSelB,
	output logic [`NUM_CHAN-1:0]      chanOn,
	output logic [`NUM_CHAN-1:0]      chanMute,
	output logic                      cfgWritePulse
);
	import vidbuf_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	tgt_state_t  state_ff;
	tgt_state_t  nxt_state;
	logic [2:0]  bitCnt_ff;
	logic [2:0]  nxt_bitCnt;
	cfg_byte_t   shift_ff;
	cfg_byte_t   nxt_shift;
	cfg_byte_t   sub_ff;
	cfg_byte_t   nxt_sub;
	cfg_byte_t   tx_ff;
	cfg_byte_t   nxt_tx;
	logic        rw_ff;
	logic        nxt_rw;
	logic        sdaOe_ff;
	logic        nxt_sdaOe;
	logic        sclPrev_ff;
	logic        sdaPrev_ff;
	logic        wrPulse_ff;
	cfg_byte_t   cfg_ff [`NUM_CHAN];
	logic [`NUM_CHAN-1:0] muxB_ff;
	logic [`NUM_CHAN-1:0] on_ff;
	logic [`NUM_CHAN-1:0] mute_ff;

	// ****************************************************************
	// Line events and decode
	// ****************************************************************
	// Start and stop are sda edges while scl stays high
	wire       sclRise   = !sclPrev_ff && link.scl;
	wire       sclFall   = sclPrev_ff && !link.scl;
	wire       startSeen = sclPrev_ff && link.scl && sdaPrev_ff && !link.sda;
	wire       stopSeen  = sclPrev_ff && link.scl && !sdaPrev_ff && link.sda;
	wire       lastBit   = (bitCnt_ff == 3'd7);
	wire [7:0] rxByte    = {shift_ff[6:0], link.sda};
	// Select pins are read at the compare itself, so they may change freely
	wire [1:0] selPins   = {addr_select_hi_pin, addr_select_lo_pin};
	wire       addrHit   = (rxByte[7:3] == `TGT_ADDR_FIXED)
	                       && (rxByte[2:1] == selPins);
	wire       subValid  = (sub_ff >= `SUBADDR_CH1) && (sub_ff <= `SUBADDR_CH3);
	wire [1:0] chanIdx   = sub_ff[1:0] - 2'd1;
	wire [7:0] rdByte    = subValid ? cfg_ff[chanIdx] : `RD_UNMAPPED;
	wire       wrStrobe  = (state_ff == T_WDAT) && sclRise && lastBit;

	// ****************************************************************
	// Transaction sequencer
	// ****************************************************************
	// Sda only moves while scl is low, so our own drive never fakes a start
	always_comb begin
		nxt_state = state_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_shift = shift_ff;
		nxt_sub = sub_ff;
		nxt_tx = tx_ff;
		nxt_rw = rw_ff;
		nxt_sdaOe = sdaOe_ff;
		if (stopSeen) begin
			nxt_state = T_IDLE; // Subaddress is kept
			nxt_sdaOe = 1'b0;
		end else if (startSeen) begin
			nxt_state = T_ADDR;
			nxt_bitCnt = 3'd0;
			nxt_sdaOe = 1'b0;
		end else begin
			case (state_ff)
				T_ADDR, T_SUB, T_WDAT: begin
					if (sclRise) begin
						nxt_shift = rxByte;
						nxt_bitCnt = bitCnt_ff + 3'd1;
						if (lastBit) begin
							case (state_ff)
								T_ADDR: begin
									nxt_rw = rxByte[0];
									nxt_state = addrHit ? T_ADDR_ACK : T_IDLE;
								end
								T_SUB: begin
									nxt_sub = rxByte;
									nxt_state = T_SUB_ACK;
								end
								default: begin
									nxt_state = T_WDAT_ACK;
								end
							endcase
						end
					end
				end
				T_ADDR_ACK, T_SUB_ACK, T_WDAT_ACK: begin
					// First falling edge pulls low, the next one releases, or drives the first read bit after a read address
					if (sclFall && !sdaOe_ff) begin
						nxt_sdaOe = 1'b1;
					end else if (sclFall) begin
						nxt_sdaOe = 1'b0;
						nxt_bitCnt = 3'd0;
						case (state_ff)
							T_ADDR_ACK: begin
								if (rw_ff == `DIR_READ) begin
									nxt_state = T_RDAT;
									nxt_tx = rdByte;
									nxt_sdaOe = !rdByte[7];
								end else begin
									nxt_state = T_SUB;
								end
							end
							T_SUB_ACK: nxt_state = T_WDAT;
							default:   nxt_state = T_DONE;
						endcase
					end
				end
				T_RDAT: begin
					if (sclRise) begin
						nxt_bitCnt = bitCnt_ff + 3'd1;
						if (lastBit) begin
							nxt_state = T_RACK;
						end
					end else if (sclFall) begin
						nxt_tx = {tx_ff[6:0], 1'b0};
						nxt_sdaOe = !tx_ff[6];
					end
				end
				T_RACK: begin
					// Controller answer is ignored: one byte only either way
					if (sclFall) begin
						nxt_sdaOe = 1'b0;
						nxt_state = T_DONE;
					end
				end
				T_IDLE, T_DONE: begin
					nxt_state = state_ff; // Further bytes go unanswered
				end
				default: begin
					nxt_state = T_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff <= T_IDLE;
			bitCnt_ff <= 3'd0;
			shift_ff <= 8'h00;
			sub_ff <= 8'h00;
			tx_ff <= 8'h00;
			rw_ff <= `DIR_WRITE;
			sdaOe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bitCnt_ff <= nxt_bitCnt;
			shift_ff <= nxt_shift;
			sub_ff <= nxt_sub;
			tx_ff <= nxt_tx;
			rw_ff <= nxt_rw;
			sdaOe_ff <= nxt_sdaOe;
		end
	end

	// Previous line levels; idle bus is high on both
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sclPrev_ff <= 1'b1;
			sdaPrev_ff <= 1'b1;
			wrPulse_ff <= 1'b0;
		end else begin
			sclPrev_ff <= link.scl;
			sdaPrev_ff <= link.sda;
			wrPulse_ff <= wrStrobe && subValid;
		end
	end

	// ****************************************************************
	// Channel configuration registers
	// ****************************************************************
	// Reset to disabled so a fresh part draws no power until configured
	for (genvar g = 0; g < `NUM_CHAN; g++) begin : gen_chan
		wire       hit  = wrStrobe && subValid && (chanIdx == 2'(g));
		wire [2:0] bias = rxByte[`CFG_BIAS_MSB:`CFG_BIAS_LSB];
		always_ff @(posedge clock or negedge nrst) begin
			if (!nrst) begin
				cfg_ff[g] <= `CFG_RESET;
				muxB_ff[g] <= 1'b0;
				on_ff[g] <= 1'b0;
				mute_ff[g] <= 1'b0;
			end else if (hit) begin
				cfg_ff[g] <= rxByte;
				muxB_ff[g] <= rxByte[`CFG_MUX_BIT];
				on_ff[g] <= (bias != `BIAS_DISABLE);
				mute_ff[g] <= (bias == `BIAS_MUTE);
			end
		end
		assign chanCfg[g] = cfg_ff[g];
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Open drain: only ever pulls low
	assign link.sdaTgtOut = 1'b0;
	assign link.sdaTgtOe = sdaOe_ff;
	assign inputSelB = muxB_ff;
	assign chanOn = on_ff;
	assign chanMute = mute_ff;
	assign cfgWritePulse = wrPulse_ff;
endmodule

// ==== verilog/i2c_channel_controller.sv ====
/*
 * Bus controller end: turns one user request into a full channel write or a
 * two-phase channel read on the two-wire link.
 * Assumes the target never stretches scl; scl is not read back.
 */
`include "vidbuf_defines.svh"

module i2c_channel_controller #(
	parameter int SCL_HALF_CYC = `SCL_HALF_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 nrst,
	i2c_link_if.ctl                   link,
	input  wire logic                 reqValid,
	input  wire logic                 reqRead,
	input  wire logic [1:0]           reqDevSel,
	input  wire logic [1:0]           reqChan,
	input  vidbuf_pkg::cfg_byte_t     reqData,
	output logic                      reqReady,
	output logic                      rspValid,
	output vidbuf_pkg::cfg_byte_t     rspData,
	output logic                      rspNack
);
	import vidbuf_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	ctl_state_t state_ff;
	logic [15:0] half_ff;
	logic [1:0]  step_ff;
	logic [3:0]  bitIdx_ff;
	logic [1:0]  byteIdx_ff;
	logic        read_ff;
	logic        phase2_ff;
	logic [1:0]  dev_ff;
	logic [1:0]  chan_ff;
	cfg_byte_t   data_ff;
	cfg_byte_t   tx_ff;
	cfg_byte_t   rx_ff;
	logic        sclOe_ff;
	logic        sdaOe_ff;
	logic        ready_ff;
	logic        valid_ff;
	logic        nack_ff;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire       tick      = (half_ff == 16'(SCL_HALF_CYC - 1));
	wire       take      = reqValid && ready_ff;
	wire [7:0] addrByte  = {`TGT_ADDR_FIXED, dev_ff, phase2_ff};
	wire [7:0] subByte   = {6'h00, chan_ff};
	wire       receiving = phase2_ff && (byteIdx_ff == 2'd1);
	// Write ends after data, both read phases after their second byte
	wire       lastByte  = (read_ff || phase2_ff) ? (byteIdx_ff == 2'd1)
	                       : (byteIdx_ff == 2'd2);
	wire [7:0] nextTx    = (byteIdx_ff == 2'd0) ? subByte : data_ff;
	wire       ackSlot   = (bitIdx_ff == 4'd8);
	wire       slaveNack = !receiving && link.sda;

	// Half-period timer, idle while no transfer runs
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			half_ff <= 16'h0000;
		end else begin
			half_ff <= (state_ff == C_IDLE || tick) ? 16'h0000 : half_ff + 16'h0001;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// One step per half scl period; data moves only while scl is low
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff <= C_IDLE;
			step_ff <= 2'd0;
			bitIdx_ff <= 4'd0;
			byteIdx_ff <= 2'd0;
			read_ff <= 1'b0;
			phase2_ff <= 1'b0;
			dev_ff <= 2'd0;
			chan_ff <= 2'd0;
			data_ff <= 8'h00;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			sclOe_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			ready_ff <= 1'b1;
			valid_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else begin
			valid_ff <= 1'b0;
			case (state_ff)
				C_IDLE: begin
					if (take) begin
						state_ff <= C_START;
						step_ff <= 2'd0;
						read_ff <= reqRead;
						dev_ff <= reqDevSel;
						chan_ff <= reqChan;
						data_ff <= reqData;
						phase2_ff <= 1'b0;
						nack_ff <= 1'b0;
						ready_ff <= 1'b0;
					end
				end
				C_START: begin
					if (tick && step_ff == 2'd0) begin
						sdaOe_ff <= 1'b1; // Start: sda falls, scl high
						step_ff <= 2'd1;
					end else if (tick) begin
						sclOe_ff <= 1'b1;
						sdaOe_ff <= !addrByte[7];
						tx_ff <= addrByte;
						bitIdx_ff <= 4'd0;
						byteIdx_ff <= 2'd0;
						step_ff <= 2'd0;
						state_ff <= C_BIT;
					end
				end
				C_BIT: begin
					if (tick && step_ff == 2'd0) begin
						sclOe_ff <= 1'b0;
						step_ff <= 2'd1;
					end else if (tick && !ackSlot) begin
						sclOe_ff <= 1'b1;
						step_ff <= 2'd0;
						bitIdx_ff <= bitIdx_ff + 4'd1;
						rx_ff <= {rx_ff[6:0], link.sda};
						tx_ff <= {tx_ff[6:0], 1'b0};
						// Ack slot released: target acks, or our read nack
						sdaOe_ff <= (bitIdx_ff == 4'd7 || receiving) ? 1'b0 : !tx_ff[6];
					end else if (tick) begin
						sclOe_ff <= 1'b1;
						step_ff <= 2'd0;
						if (slaveNack || lastByte) begin
							nack_ff <= nack_ff || slaveNack;
							sdaOe_ff <= 1'b1;
							state_ff <= C_STOP;
						end else begin
							byteIdx_ff <= byteIdx_ff + 2'd1;
							bitIdx_ff <= 4'd0;
							tx_ff <= nextTx;
							sdaOe_ff <= phase2_ff ? 1'b0 : !nextTx[7];
						end
					end
				end
				C_STOP: begin
					if (tick && step_ff == 2'd0) begin
						sclOe_ff <= 1'b0;
						step_ff <= 2'd1;
					end else if (tick && step_ff == 2'd1) begin
						sdaOe_ff <= 1'b0; // Stop: sda rises, scl high
						step_ff <= 2'd2;
					end else if (tick) begin
						step_ff <= 2'd0;
						if (read_ff && !phase2_ff && !nack_ff) begin
							phase2_ff <= 1'b1;
							state_ff <= C_START;
						end else begin
							state_ff <= C_IDLE; // One byte per request
							valid_ff <= 1'b1;
							ready_ff <= 1'b1;
						end
					end
				end
				default: begin
					state_ff <= C_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Open drain on both lines: drive low or release
	assign link.sclCtlOut = 1'b0;
	assign link.sclCtlOe = sclOe_ff;
	assign link.sdaCtlOut = 1'b0;
	assign link.sdaCtlOe = sdaOe_ff;
	assign reqReady = ready_ff;
	assign rspValid = valid_ff;
	assign rspData = rx_ff;
	assign rspNack = nack_ff;
endmodule

// ==== verification/vidbuf_link_assertions.sv ====
/*
 * Link checker for the controller and video buffer target on the two-wire link.
 * Assumes it is instantiated beside the link interface, every input by name.
 */
`include "vidbuf_defines.svh"

module vidbuf_link_checker #(
	parameter int SCL_HALF_CYC = `SCL_HALF_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sdaTgtOe,
	input wire logic addr_select_hi_pin,
	input wire logic addr_select_lo_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Frame tracking
	// ****************************************************************
	localparam int FALL_MAX = SCL_HALF_CYC + 2;
	logic       sclPrev_ff;
	logic       sdaPrev_ff;
	logic       isRead_ff;
	logic       matched_ff;
	logic       dead_ff;
	logic [3:0] bitCnt_ff;
	logic [1:0] byteCnt_ff;
	logic [7:0] shift_ff;

	// Bus events; the ninth rise of a byte is its acknowledge slot
	wire startEv = scl && sclPrev_ff && sdaPrev_ff && !sda;
	wire stopEv  = scl && sclPrev_ff && !sdaPrev_ff && sda;
	wire riseEv  = scl && !sclPrev_ff;
	wire ackBit  = riseEv && (bitCnt_ff == 4'h8);
	wire addrHit = shift_ff[7:1] == {`TGT_ADDR_FIXED, addr_select_hi_pin, addr_select_lo_pin};

	// Shadow decoder; pins compared live at the slot, as the target must
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sclPrev_ff <= 1'b1;
			sdaPrev_ff <= 1'b1;
			isRead_ff  <= 1'b0;
			matched_ff <= 1'b0;
			dead_ff    <= 1'b0;
			bitCnt_ff  <= 4'h0;
			byteCnt_ff <= 2'h0;
			shift_ff   <= 8'h00;
		end else begin
			sclPrev_ff <= scl;
			sdaPrev_ff <= sda;
			if (startEv) begin
				bitCnt_ff  <= 4'h0;
				byteCnt_ff <= 2'h0;
				matched_ff <= 1'b0;
				dead_ff    <= 1'b0;
			end else if (riseEv) begin
				shift_ff  <= {shift_ff[6:0], sda};
				bitCnt_ff <= ackBit ? 4'h0 : bitCnt_ff + 4'h1;
				if (ackBit && byteCnt_ff != 2'h3) begin
					byteCnt_ff <= byteCnt_ff + 2'h1;
				end
				if (ackBit && byteCnt_ff == 2'h0) begin
					matched_ff <= addrHit;
					isRead_ff  <= shift_ff[0];
					dead_ff    <= !addrHit;
				end
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	AST_ADDR_ACK: assert property (
		ackBit && byteCnt_ff == 2'h0 |-> sda == !addrHit)
		else $error("address acknowledge does not follow the match");
	AST_SUB_ACK: assert property (
		ackBit && byteCnt_ff == 2'h1 && matched_ff && !isRead_ff |-> !sda)
		else $error("subaddress byte not acknowledged");
	AST_DATA_ACK: assert property (
		ackBit && byteCnt_ff == 2'h2 && matched_ff && !isRead_ff |-> !sda)
		else $error("write data byte not acknowledged");
	AST_READ_ONE_BYTE: assert property (
		ackBit && byteCnt_ff == 2'h1 && matched_ff && isRead_ff |-> !sdaTgtOe && sda)
		else $error("target holds sda after its read byte");
	AST_SILENT: assert property (
		dead_ff |-> !sdaTgtOe)
		else $error("target drives after an address mismatch");
	AST_TGT_EDGE: assert property (
		$changed(sdaTgtOe) |-> !scl && !$past(scl))
		else $error("target changed sda while scl high");
	// A level check at the stop alone would hold by construction; watch the
	// clock pulse after the last acknowledge instead, where a second byte would start
	AST_STOP_FREE: assert property (
		riseEv && matched_ff && (isRead_ff ? byteCnt_ff == 2'h2 : byteCnt_ff == 2'h3)
		|-> !sdaTgtOe)
		else $error("target still driving after its last byte");
	AST_START_FALL: assert property (
		startEv |-> ##[1:FALL_MAX] !scl)
		else $error("no clock low phase after start");
endmodule

// ==== verification/tb.sv ====
/*
 * Self-checking bench: controller and target joined through the link interface.
 * Assumes package, header, interface and both ends are compiled before it.
 */
`include "vidbuf_defines.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vidbuf_pkg::*;

	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	localparam int HALF = 8;
	logic                 clock, nrst, reqValid, reqRead, addrSelHi, addrSelLo;
	logic                 reqReady, rspValid, rspNack, cfgWritePulse;
	logic [1:0]           reqDevSel, reqChan;
	cfg_byte_t            reqData, rspData;
	cfg_byte_t            chanCfg [`NUM_CHAN];
	cfg_byte_t            shadow [`NUM_CHAN];
	logic [`NUM_CHAN-1:0] inputSelB, chanOn, chanMute;
	int                   err_total, samples_checked, pulses;

	i2c_link_if linkBus ();
	vidbuf_i2c_target vidbuf_i2c_target_inst (.clock(clock), .nrst(nrst), .link(linkBus),
		.addr_select_hi_pin(addrSelHi), .addr_select_lo_pin(addrSelLo), .chanCfg(chanCfg),
		.inputSelB(inputSelB), .chanOn(chanOn), .chanMute(chanMute),
		.cfgWritePulse(cfgWritePulse));
	i2c_channel_controller #(.SCL_HALF_CYC(HALF)) i2c_channel_controller_inst (.clock(clock),
		.nrst(nrst), .link(linkBus), .reqValid(reqValid), .reqRead(reqRead),
		.reqDevSel(reqDevSel), .reqChan(reqChan), .reqData(reqData), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData), .rspNack(rspNack));
	vidbuf_link_checker #(.SCL_HALF_CYC(HALF)) vidbuf_link_checker_inst (.clock(clock),
		.nrst(nrst), .scl(linkBus.scl), .sda(linkBus.sda), .sdaTgtOe(linkBus.sdaTgtOe),
		.addr_select_hi_pin(addrSelHi), .addr_select_lo_pin(addrSelLo));

	// Free-running 100 MHz clock
	always #5 clock = ~clock;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s seen %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One user request, held one edge, then a bounded wait for the response pulse
	task automatic transfer(input logic rd, input logic [1:0] dev, input logic [1:0] ch,
		input cfg_byte_t data);
		int n;
		@(posedge clock);
		#1;
		reqValid = 1'b1;
		reqRead = rd;
		reqDevSel = dev;
		reqChan = ch;
		reqData = data;
		@(posedge clock);
		#1;
		reqValid = 1'b0;
		check(reqReady, 1'b0, "ready while busy");
		pulses = 0;
		for (n = 0; n < 3000 && rspValid !== 1'b1; n++) begin
			@(posedge clock);
			#1;
			if (cfgWritePulse === 1'b1) pulses++;
		end
		check(reqReady, 1'b1, "ready at end");
		if (n == 3000) begin
			err_total++;
			$display("wrong value at %0t: no response", $time);
		end
	endtask

	// All channel outputs against the expected bytes
	task automatic check_cfg();
		for (int i = 0; i < `NUM_CHAN; i++) begin
			check(chanCfg[i], shadow[i], "channel byte");
			check(inputSelB[i], shadow[i][`CFG_MUX_BIT], "mux select");
			check(chanOn[i], shadow[i][2:0] != `BIAS_DISABLE, "channel on");
			check(chanMute[i], shadow[i][2:0] == `BIAS_MUTE, "channel mute");
		end
	endtask

	task automatic wr(input logic [1:0] ch, input cfg_byte_t d);
		transfer(1'b0, {addrSelHi, addrSelLo}, ch, d);
		if (ch != 2'h0) shadow[ch-1] = d;
		check(rspNack, 1'b0, "write nack");
		check(pulses, (ch != 2'h0), "store pulses");
		check_cfg();
	endtask

	task automatic rd(input logic [1:0] ch);
		transfer(1'b1, {addrSelHi, addrSelLo}, ch, 8'h00);
		check(rspNack, 1'b0, "read nack");
		check(rspData, (ch == 2'h0) ? `RD_UNMAPPED : shadow[ch-1], "read byte");
		check(pulses, 0, "read stored");
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset();
		check_cfg();
		check(rspNack, 1'b0, "reset nack");
		$display("test_reset done");
	endtask

	// Every channel, both mux inputs, disable and mute codes
	task automatic test_write();
		wr(2'h1, 8'hf5);
		wr(2'h2, 8'h01);
		wr(2'h3, 8'h20);
		$display("test_write done");
	endtask

	// Subaddress kept across the stop between the two read phases
	task automatic test_read();
		for (int c = 1; c <= `NUM_CHAN; c++) rd(c[1:0]);
		$display("test_read done");
	endtask

	// Pins moved between frames: a wrong address is refused, the right one served
	task automatic test_addr_select();
		for (int p = 0; p < 4; p++) begin
			@(posedge clock);
			#1;
			{addrSelHi, addrSelLo} = p[1:0];
			transfer(1'b0, p[1:0] ^ 2'h1, 2'h2, 8'hff);
			check(rspNack, 1'b1, "foreign address");
			check(pulses, 0, "foreign stored");
			wr(2'h2, {p[1:0], 6'h02});
		end
		rd(2'h2);
		$display("test_addr_select done");
	endtask

	// Subaddress zero is acknowledged but holds nothing
	task automatic test_bad_sub();
		wr(2'h0, 8'haa);
		rd(2'h0);
		rd(2'h1);
		$display("test_bad_sub done");
	endtask

	// Reset in mid-run returns every channel to its disabled state
	task automatic test_mid_reset();
		wr(2'h1, 8'h3e);
		@(posedge clock);
		#1;
		nrst = 1'b0;
		repeat (10) @(posedge clock);
		#1;
		nrst = 1'b1;
		foreach (shadow[i]) shadow[i] = `CFG_RESET;
		check_cfg();
		check(cfgWritePulse, 1'b0, "reset pulse");
		check(reqReady, 1'b1, "reset ready");
		rd(2'h1);
		$display("test_mid_reset done");
	endtask

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		reqValid = 1'b0;
		reqRead = 1'b0;
		reqDevSel = 2'h0;
		reqChan = 2'h0;
		reqData = 8'h00;
		addrSelHi = 1'b0;
		addrSelLo = 1'b1;
		err_total = 0;
		samples_checked = 0;
		foreach (shadow[i]) shadow[i] = `CFG_RESET;
		repeat (10) @(posedge clock);
		#1;
		nrst = 1'b1;
		test_reset();
		test_write();
		test_read();
		test_addr_select();
		test_bad_sub();
		test_mid_reset();
		results();
	end

	// Run needs about 10000 cycles; the margin covers a slow but live design
	initial begin
		#300000;
		err_total++;
		$display("wrong value at %0t: watchdog expired", $time);
		results();
	end
endmodule
